// *** otp_dev.sv ***
// Device end: OTP array, lock fuses, encryption and verify
`timescale 1ns/1ps
`include "otp_defs.svh"
module otp_dev import otp_pkg::*; #(
  parameter logic [7:0]  MAKER_CODE  = 8'h5a, // Arbitrary value
  parameter logic [7:0]  PART_CODE   = 8'ha5, // Arbitrary value
  parameter logic [12:0] LOW_MIN_CYC = 13'(`OTP_LOW_MIN_CYC),
  parameter logic [12:0] LOW_MAX_CYC = 13'(`OTP_LOW_MAX_CYC)
) (
  input  wire logic CLK,
  input  wire logic SRST,
  otp_pins_if.dev   PINS,
  output logic      FIRST_LOCK_FUSE,
  output logic      SECOND_LOCK_FUSE,
  output logic      WRITE_DONE,
  output logic      WRITE_REFUSED
);
  localparam int SYNC_W = 10 + `OTP_ADDR_W + `OTP_DATA_W;

  logic [SYNC_W-1:0]          pins_raw;
  logic [SYNC_W-1:0]          pins_s;
  logic                       rst_s;
  logic                       msa_s;
  logic                       msb_s;
  logic                       msc_s;
  logic                       msd_s;
  logic                       mse_s;
  logic                       msf_s;
  logic                       strb_s;
  logic                       irq_s;
  logic                       vpp_s;
  logic [`OTP_ADDR_W-1:0]     addr_s;
  logic [`OTP_DATA_W-1:0]     data_s;

  logic [`OTP_DATA_W-1:0]     code_mem [0:`OTP_MEM_DEPTH-1];
  logic [`OTP_DATA_W-1:0]     enc_ff   [0:`OTP_ENC_DEPTH-1];
  logic                       strb_q_ff;
  logic [`OTP_TMR_W-1:0]      low_cnt_ff;
  logic [`OTP_CNT_W-1:0]      pulse_cnt_ff;
  otp_mode_type               seq_mode_ff;
  logic [`OTP_DATA_W-1:0]     rd_code_ff;
  logic [`OTP_DATA_W-1:0]     rd_enc_ff;
  logic [`OTP_DATA_W-1:0]     p0_out_ff;
  logic                       p0_oe_ff;

  // All pins come from the programmer's domain
  assign pins_raw = {PINS.reset_pin, PINS.mode_select_a,
                     PINS.mode_select_b, PINS.mode_select_c,
                     PINS.mode_select_d, PINS.mode_select_e,
                     PINS.mode_select_f, PINS.program_strobe,
                     PINS.external_irq_zero_pin, PINS.vpp_applied,
                     PINS.vertical_sync_input_pin, PINS.port2_low,
                     PINS.port1, PINS.port0_level};

  otp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .CLK  (CLK),
    .SRST (SRST),
    .D    (pins_raw),
    .Q    (pins_s)
  );

  assign {rst_s, msa_s, msb_s, msc_s, msd_s, mse_s, msf_s, strb_s,
          irq_s, vpp_s, addr_s, data_s} = pins_s;

  // Mode decode from static pin levels
  wire       base_lvl = !rst_s && !msb_s && msa_s;
  wire [3:0] sel      = {msf_s, mse_s, msd_s, msc_s};
  wire       rd_lvl   = base_lvl && strb_s && irq_s && !vpp_s;
  wire       pg_lvl   = base_lvl && vpp_s;

  wire is_sig    = rd_lvl && (sel == `OTP_SEL_SIG);
  wire is_verify = rd_lvl && (sel == `OTP_SEL_VERIFY);
  wire is_code   = pg_lvl && (sel == `OTP_SEL_CODE);
  wire is_enc    = pg_lvl && (sel == `OTP_SEL_ENC);
  wire is_lb1    = pg_lvl && (sel == `OTP_SEL_LB1);
  wire is_lb2    = pg_lvl && (sel == `OTP_SEL_LB2);

  otp_mode_type mode_w;
  assign mode_w = is_sig    ? MD_SIG    :
                  is_verify ? MD_VERIFY :
                  is_code   ? MD_CODE   :
                  is_enc    ? MD_ENC    :
                  is_lb1    ? MD_LB1    :
                  is_lb2    ? MD_LB2    : MD_NONE;

  wire is_program_strobe   = is_code || is_enc || is_lb1 || is_lb2;

  // Strobe sequence qualification
  wire strb_rise = strb_s && !strb_q_ff;
  wire same_mode = (mode_w == seq_mode_ff);
  wire low_ok    = (low_cnt_ff >= LOW_MIN_CYC) &&
                   (low_cnt_ff <= LOW_MAX_CYC);
  wire last_pls  = (pulse_cnt_ff == (`OTP_PULSES - 4'h1));
  wire seq_fire  = is_program_strobe && same_mode && strb_rise && low_ok &&
                   last_pls;
  wire low_sat   = &low_cnt_ff;

  // Either fuse blocks array writes, never the other fuse
  wire mem_open  = !FIRST_LOCK_FUSE && !SECOND_LOCK_FUSE;
  wire code_wr   = seq_fire && is_code && mem_open;
  wire enc_wr    = seq_fire && is_enc && mem_open;
  wire lb1_wr    = seq_fire && is_lb1;
  wire lb2_wr    = seq_fire && is_lb2;
  wire refuse    = seq_fire && (is_code || is_enc) && !mem_open;

  wire [`OTP_ENC_IDX_W-1:0] enc_idx = addr_s[`OTP_ENC_IDX_W-1:0];

  wire [`OTP_DATA_W-1:0] sig_byte =
    (addr_s == `OTP_SIG_MAKER_ADDR) ? MAKER_CODE :
    (addr_s == `OTP_SIG_PART_ADDR)  ? PART_CODE  :
    `OTP_BLANK_BYTE;

  // Table content only ever leaves as part of the XNOR
  wire [`OTP_DATA_W-1:0] vfy_byte = ~(rd_code_ff ^ rd_enc_ff);
  wire verify_ok = is_verify && !SECOND_LOCK_FUSE;
  wire drive_p0  = verify_ok || is_sig;
  wire [`OTP_DATA_W-1:0] nxt_p0_out =
    is_sig    ? sig_byte :
    verify_ok ? vfy_byte : `OTP_BLANK_BYTE;

  // Code array starts blank; kept across SRST like real cells
  initial begin
    for (int i = 0; i < `OTP_MEM_DEPTH; i++) begin
      code_mem[i] = `OTP_BLANK_BYTE;
    end
  end

  // Cells can only lose ones, so writes AND into the cell
  // Plain always: the initial blank fill also writes this array
  always @(posedge CLK) begin
    if (code_wr) begin
      code_mem[addr_s] <= code_mem[addr_s] & data_s;
    end
    rd_code_ff <= code_mem[addr_s];
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < `OTP_ENC_DEPTH; i++) begin
        enc_ff[i] <= `OTP_BLANK_BYTE;
      end
    end else if (enc_wr) begin
      enc_ff[enc_idx] <= enc_ff[enc_idx] & data_s;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rd_enc_ff <= `OTP_BLANK_BYTE;
    end else begin
      rd_enc_ff <= enc_ff[enc_idx];
    end
  end

  // A pulse out of tolerance or a mode change restarts the count
  always_ff @(posedge CLK) begin
    if (SRST) begin
      strb_q_ff    <= 1'b1;
      low_cnt_ff   <= '0;
      pulse_cnt_ff <= '0;
      seq_mode_ff  <= MD_NONE;
    end else begin
      strb_q_ff   <= strb_s;
      seq_mode_ff <= mode_w;
      if (strb_s) begin
        low_cnt_ff <= '0;
      end else if (!low_sat) begin
        low_cnt_ff <= low_cnt_ff + 13'h0001;
      end
      if (!is_program_strobe || !same_mode) begin
        pulse_cnt_ff <= '0;
      end else if (strb_rise) begin
        pulse_cnt_ff <= (low_ok && !last_pls) ?
                        pulse_cnt_ff + 4'h1 : 4'h0;
      end
    end
  end

  // Fuses and outputs
  always_ff @(posedge CLK) begin
    if (SRST) begin
      FIRST_LOCK_FUSE  <= 1'b0;
      SECOND_LOCK_FUSE <= 1'b0;
      WRITE_DONE       <= 1'b0;
      WRITE_REFUSED    <= 1'b0;
      p0_out_ff        <= `OTP_BLANK_BYTE;
      p0_oe_ff         <= 1'b0;
    end else begin
      FIRST_LOCK_FUSE  <= FIRST_LOCK_FUSE || lb1_wr;
      SECOND_LOCK_FUSE <= SECOND_LOCK_FUSE || lb2_wr;
      WRITE_DONE       <= code_wr || enc_wr || lb1_wr || lb2_wr;
      WRITE_REFUSED    <= refuse;
      p0_out_ff        <= nxt_p0_out;
      p0_oe_ff         <= drive_p0;
    end
  end

  assign PINS.port0_dev_out = p0_out_ff;
  assign PINS.port0_dev_oe  = p0_oe_ff;
endmodule : otp_dev

// *** otp_defs.svh ***
// Shared constants for the OTP program and verify port
`ifndef OTP_DEFS_SVH
`define OTP_DEFS_SVH

`define OTP_CLK_MHZ        40
`define OTP_ADDR_W         15
`define OTP_DATA_W         8
`define OTP_MEM_DEPTH      32768
`define OTP_ENC_DEPTH      64
`define OTP_ENC_IDX_W      6
`define OTP_TMR_W          13
`define OTP_CNT_W          4
`define OTP_PULSES         4'ha
`define OTP_BLANK_BYTE     8'hff
`define OTP_SIG_MAKER_ADDR 15'h0030
`define OTP_SIG_PART_ADDR  15'h0020

// Select pin codes, order F E D C
`define OTP_SEL_SIG        4'h0
`define OTP_SEL_VERIFY     4'h3
`define OTP_SEL_CODE       4'hb
`define OTP_SEL_ENC        4'ha
`define OTP_SEL_LB1        4'hf
`define OTP_SEL_LB2        4'hc
`define OTP_SEL_IDLE       4'h1

// Times in microseconds and derived cycle counts
`define OTP_LOW_US         100
`define OTP_LOW_TOL_US     10
`define OTP_HIGH_MIN_US    10
`define OTP_SETUP_US       12
`define OTP_HOLD_US        12
`define OTP_LOW_CYC        (`OTP_LOW_US*`OTP_CLK_MHZ)
`define OTP_LOW_MIN_CYC    ((`OTP_LOW_US-`OTP_LOW_TOL_US)*`OTP_CLK_MHZ)
`define OTP_LOW_MAX_CYC    ((`OTP_LOW_US+`OTP_LOW_TOL_US)*`OTP_CLK_MHZ)
`define OTP_HIGH_CYC       (`OTP_HIGH_MIN_US*`OTP_CLK_MHZ)
`define OTP_SETUP_CYC      (`OTP_SETUP_US*`OTP_CLK_MHZ)
`define OTP_HOLD_CYC       (`OTP_HOLD_US*`OTP_CLK_MHZ)

// Programmer register map
`define OTP_REG_CTRL       8'h00
`define OTP_REG_ADDR       8'h04
`define OTP_REG_WDATA      8'h08
`define OTP_REG_STATUS     8'h0c
`define OTP_CTRL_START_BIT 8
`define OTP_STAT_BUSY_BIT  0
`define OTP_STAT_DONE_BIT  1
`endif

// *** otp_pkg.sv ***
// Types shared by both ends of the OTP port
package otp_pkg;
  typedef enum logic [2:0] {
    OP_PROGRAM_STROBE_CODE,
    OP_VERIFY,
    OP_PROGRAM_STROBE_ENC,
    OP_PROGRAM_STROBE_LB1,
    OP_PROGRAM_STROBE_LB2,
    OP_READ_SIG
  } otp_op_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_HOLD
  } otp_state_type;

  typedef enum logic [2:0] {
    MD_NONE,
    MD_SIG,
    MD_VERIFY,
    MD_CODE,
    MD_ENC,
    MD_LB1,
    MD_LB2
  } otp_mode_type;
endpackage : otp_pkg

// *** otp_pins_if.sv ***
// Pin bundle between the programmer and the device
`timescale 1ns/1ps
interface otp_pins_if;
  logic       reset_pin;
  logic       mode_select_a;
  logic       mode_select_b;
  logic       mode_select_c;
  logic       mode_select_d;
  logic       mode_select_e;
  logic       mode_select_f;
  logic       program_strobe;
  logic       external_irq_zero_pin;
  logic       vpp_applied;
  logic [7:0] port1;
  logic [5:0] port2_low;
  logic       vertical_sync_input_pin;
  logic [7:0] port0_prg_out;
  logic       port0_prg_oe;
  logic [7:0] port0_dev_out;
  logic       port0_dev_oe;
  logic [7:0] port0_level;

  // Undriven port 0 floats high through its pull-ups
  assign port0_level = port0_dev_oe ? port0_dev_out :
                       (port0_prg_oe ? port0_prg_out : 8'hff);

  modport dev (
    input  reset_pin, mode_select_a, mode_select_b, mode_select_c,
    input  mode_select_d, mode_select_e, mode_select_f, program_strobe,
    input  external_irq_zero_pin, vpp_applied, port1, port2_low,
    input  vertical_sync_input_pin, port0_level,
    output port0_dev_out, port0_dev_oe
  );

  modport prg (
    output reset_pin, mode_select_a, mode_select_b, mode_select_c,
    output mode_select_d, mode_select_e, mode_select_f, program_strobe,
    output external_irq_zero_pin, vpp_applied, port1, port2_low,
    output vertical_sync_input_pin, port0_prg_out, port0_prg_oe,
    input  port0_level
  );
endinterface : otp_pins_if

// *** otp_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module otp_sync #(
  parameter int W = 1
) (
  input  wire logic         CLK,
  input  wire logic         SRST,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second
  always_ff @(posedge CLK) begin
    if (SRST) begin
      meta_ff <= '0;
      Q       <= '0;
    end else begin
      meta_ff <= D;
      Q       <= meta_ff;
    end
  end
endmodule : otp_sync

// *** otp_prg.sv ***
// Programmer end: APB registers and pin sequencer
`timescale 1ns/1ps
`include "otp_defs.svh"
module otp_prg import otp_pkg::*; (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  otp_pins_if.prg          PINS
);
  logic [2:0]             op_ff;
  logic [`OTP_ADDR_W-1:0] addr_ff;
  logic [`OTP_DATA_W-1:0] wdata_ff;
  logic [`OTP_DATA_W-1:0] rdata_ff;
  logic                   busy_ff;
  logic                   done_ff;
  otp_state_type          state_ff;
  logic [`OTP_TMR_W-1:0]  tmr_ff;
  logic [`OTP_CNT_W-1:0]  pulses_ff;
  logic [3:0]             sel_ff;
  logic                   strb_ff;
  logic                   vpp_ff;
  logic                   p0_oe_ff;
  logic [`OTP_DATA_W-1:0] p0_s;

  otp_sync #(
    .W (`OTP_DATA_W)
  ) u_p0_sync (
    .CLK  (CLK),
    .SRST (SRST),
    .D    (PINS.port0_level),
    .Q    (p0_s)
  );

  // APB decode; registers answer on the second access cycle
  wire access   = PSEL && PENABLE;
  wire first    = access && !PREADY;
  wire take     = access && PREADY;
  wire hit_ctrl = (PADDR == `OTP_REG_CTRL);
  wire hit_addr = (PADDR == `OTP_REG_ADDR);
  wire hit_wdat = (PADDR == `OTP_REG_WDATA);
  wire hit_stat = (PADDR == `OTP_REG_STATUS);
  wire mapped   = hit_ctrl || hit_addr || hit_wdat || hit_stat;
  wire wr_ok    = take && PWRITE && !busy_ff;
  wire start    = wr_ok && hit_ctrl && PWDATA[`OTP_CTRL_START_BIT];
  wire [2:0] nxt_op = start ? PWDATA[2:0] : op_ff;
  wire legal    = (nxt_op <= OP_READ_SIG);
  wire is_program_strobe  = (nxt_op != OP_VERIFY) && (nxt_op != OP_READ_SIG);
  wire clr_done = take && PWRITE && hit_stat &&
                  PWDATA[`OTP_STAT_DONE_BIT];
  wire tmr_zero = (tmr_ff == '0);
  wire fin      = (state_ff == ST_HOLD) && tmr_zero;

  wire [31:0] rd_mux =
    hit_ctrl ? {29'h0, op_ff} :
    hit_addr ? {17'h0, addr_ff} :
    hit_wdat ? {24'h0, wdata_ff} :
    hit_stat ? {16'h0, rdata_ff, 6'h0, done_ff, busy_ff} : 32'h0;

  // Select pin levels for each operation
  wire [3:0] op_sel =
    (nxt_op == OP_PROGRAM_STROBE_CODE) ? `OTP_SEL_CODE :
    (nxt_op == OP_VERIFY)    ? `OTP_SEL_VERIFY :
    (nxt_op == OP_PROGRAM_STROBE_ENC)  ? `OTP_SEL_ENC :
    (nxt_op == OP_PROGRAM_STROBE_LB1)  ? `OTP_SEL_LB1 :
    (nxt_op == OP_PROGRAM_STROBE_LB2)  ? `OTP_SEL_LB2 :
    `OTP_SEL_SIG;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0;
    end else begin
      PREADY  <= first;
      PSLVERR <= first && !mapped;
      PRDATA  <= first ? rd_mux : 32'h0;
    end
  end

  // Control, address and write data registers are frozen while a sequence runs
  always_ff @(posedge CLK) begin
    if (SRST) begin
      op_ff    <= 3'h0;
      addr_ff  <= '0;
      wdata_ff <= '0;
      done_ff  <= 1'b0;
    end else begin
      op_ff   <= (wr_ok && hit_ctrl) ? PWDATA[2:0] : op_ff;
      if (wr_ok && hit_addr) begin
        addr_ff <= PWDATA[`OTP_ADDR_W-1:0];
      end
      if (wr_ok && hit_wdat) begin
        wdata_ff <= PWDATA[`OTP_DATA_W-1:0];
      end
      done_ff <= fin || (done_ff && !clr_done);
    end
  end

  // Ten low pulses for program operations; the clock keeps running throughout
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_ff  <= ST_IDLE;
      busy_ff   <= 1'b0;
      tmr_ff    <= '0;
      pulses_ff <= '0;
      sel_ff    <= `OTP_SEL_IDLE;
      strb_ff   <= 1'b1;
      vpp_ff    <= 1'b0;
      p0_oe_ff  <= 1'b0;
      rdata_ff  <= '0;
    end else begin
      if (!tmr_zero) begin
        tmr_ff <= tmr_ff - 13'h0001;
      end
      unique case (state_ff)
        ST_IDLE: if (start && legal) begin
          busy_ff  <= 1'b1;
          sel_ff   <= op_sel;
          vpp_ff   <= is_program_strobe;
          p0_oe_ff <= is_program_strobe;
          tmr_ff   <= 13'(`OTP_SETUP_CYC - 1);
          state_ff <= ST_SETUP;
        end
        ST_SETUP: if (tmr_zero) begin
          if (vpp_ff) begin
            strb_ff   <= 1'b0;
            pulses_ff <= '0;
            tmr_ff    <= 13'(`OTP_LOW_CYC - 1);
            state_ff  <= ST_LOW;
          end else begin
            rdata_ff <= p0_s;
            tmr_ff   <= 13'(`OTP_HOLD_CYC - 1);
            state_ff <= ST_HOLD;
          end
        end
        ST_LOW: if (tmr_zero) begin
          strb_ff   <= 1'b1;
          pulses_ff <= pulses_ff + 4'h1;
          tmr_ff    <= 13'(`OTP_HIGH_CYC - 1);
          state_ff  <= ST_HIGH;
        end
        ST_HIGH: if (tmr_zero) begin
          if (pulses_ff == `OTP_PULSES) begin
            tmr_ff   <= 13'(`OTP_HOLD_CYC - 1);
            state_ff <= ST_HOLD;
          end else begin
            strb_ff  <= 1'b0;
            tmr_ff   <= 13'(`OTP_LOW_CYC - 1);
            state_ff <= ST_LOW;
          end
        end
        ST_HOLD: if (tmr_zero) begin
          busy_ff  <= 1'b0;
          sel_ff   <= `OTP_SEL_IDLE;
          vpp_ff   <= 1'b0;
          p0_oe_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Reset pin held low, select B low, A and irq pin high
  assign PINS.reset_pin               = 1'b0;
  assign PINS.mode_select_a           = 1'b1;
  assign PINS.mode_select_b           = 1'b0;
  assign PINS.external_irq_zero_pin   = 1'b1;
  assign {PINS.mode_select_f, PINS.mode_select_e,
          PINS.mode_select_d, PINS.mode_select_c} = sel_ff;
  assign PINS.program_strobe          = strb_ff;
  assign PINS.vpp_applied             = vpp_ff;
  assign PINS.port1                   = addr_ff[7:0];
  assign PINS.port2_low               = addr_ff[13:8];
  assign PINS.vertical_sync_input_pin = addr_ff[14];
  assign PINS.port0_prg_out           = wdata_ff;
  assign PINS.port0_prg_oe            = p0_oe_ff;
endmodule : otp_prg

// *** otp_chk.sv ***
// Concurrent checks on the pins between programmer and device
`timescale 1ns/1ps
`include "otp_defs.svh"
module otp_chk #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'ha5  // Arbitrary value
) (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic       reset_pin,
  input wire logic       mode_select_a,
  input wire logic       mode_select_b,
  input wire logic       mode_select_c,
  input wire logic       mode_select_d,
  input wire logic       mode_select_e,
  input wire logic       mode_select_f,
  input wire logic       program_strobe,
  input wire logic       vpp_applied,
  input wire logic [7:0] port1,
  input wire logic [5:0] port2_low,
  input wire logic       vertical_sync_input_pin,
  input wire logic       port0_prg_oe,
  input wire logic [7:0] port0_dev_out,
  input wire logic       port0_dev_oe
);
  logic [3:0]  sel;
  logic [14:0] addr;
  logic [12:0] low_cnt_ff;
  logic [12:0] high_cnt_ff;

  assign sel  = {mode_select_f, mode_select_e, mode_select_d, mode_select_c};
  assign addr = {vertical_sync_input_pin, port2_low, port1};

  // Saturate so a stuck strobe never wraps back into the legal window
  always_ff @(posedge CLK) begin
    if (SRST || program_strobe) low_cnt_ff <= 13'h0;
    else if (low_cnt_ff != 13'h1fff) low_cnt_ff <= low_cnt_ff + 13'h1;
  end

  always_ff @(posedge CLK) begin
    if (SRST || !program_strobe) high_cnt_ff <= 13'h0;
    else if (high_cnt_ff != 13'h1fff) high_cnt_ff <= high_cnt_ff + 13'h1;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  // Read levels and address held long enough for the device to answer
  sequence read_held(code);
    (sel == code && !vpp_applied && $stable(addr))[*6];
  endsequence

  chk_fixed_pins: assert property (!reset_pin && mode_select_a && !mode_select_b)
    else $error("fixed programming levels broken");
  chk_strobe_vpp: assert property (!program_strobe |-> vpp_applied)
    else $error("strobe low without programming supply");
  chk_low_width: assert property ($rose(program_strobe) |->
    low_cnt_ff >= `OTP_LOW_MIN_CYC && low_cnt_ff <= `OTP_LOW_MAX_CYC)
    else $error("strobe low phase out of range");
  chk_high_width: assert property ($fell(program_strobe) |->
    high_cnt_ff >= `OTP_HIGH_CYC)
    else $error("strobe high phase too short");
  chk_vpp_setup: assert property ($fell(program_strobe) |->
    $past(vpp_applied, 400))
    else $error("supply not set up before strobe");
  chk_steady_levels: assert property (!program_strobe |->
    $stable(sel) && $stable(addr) && $stable(vpp_applied))
    else $error("levels moved during strobe");
  chk_oe_modes: assert property ($rose(port0_dev_oe) |->
    (sel == `OTP_SEL_SIG || sel == `OTP_SEL_VERIFY) && !vpp_applied)
    else $error("device drives port 0 outside read modes");
  chk_prg_oe_modes: assert property (port0_prg_oe |->
    sel != `OTP_SEL_SIG && sel != `OTP_SEL_VERIFY)
    else $error("programmer drives port 0 in read mode");
  chk_sig_drive: assert property (read_held(`OTP_SEL_SIG) |-> port0_dev_oe)
    else $error("signature not driven");
  chk_maker_value: assert property (read_held(`OTP_SEL_SIG) ##0
    addr == `OTP_SIG_MAKER_ADDR |-> port0_dev_out == MAKER_CODE)
    else $error("maker signature wrong");
  chk_part_value: assert property (read_held(`OTP_SEL_SIG) ##0
    addr == `OTP_SIG_PART_ADDR |-> port0_dev_out == PART_CODE)
    else $error("part signature wrong");
endmodule : otp_chk

// *** otp_program_verify_port_test.sv ***
// Self-checking bench joining the programmer and device ends
`timescale 1ns/1ps
`include "otp_defs.svh"
module otp_program_verify_port_test;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
  localparam logic [7:0] PART  = 8'hc3; // Arbitrary value
  logic        CLK;
  logic        SRST;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        fuse_one, fuse_two, wr_done, wr_refused;
  int          n_done, n_refused;
  int          errors;
  int          n_compared;

  otp_pins_if otp_pins_if_inst ();
  otp_prg otp_prg_inst (.CLK(CLK), .SRST(SRST), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PINS(otp_pins_if_inst.prg));
  otp_dev #(.MAKER_CODE(MAKER), .PART_CODE(PART)) otp_dev_inst (
    .CLK(CLK), .SRST(SRST), .PINS(otp_pins_if_inst.dev),
    .FIRST_LOCK_FUSE(fuse_one), .SECOND_LOCK_FUSE(fuse_two),
    .WRITE_DONE(wr_done), .WRITE_REFUSED(wr_refused));
  otp_chk #(.MAKER_CODE(MAKER), .PART_CODE(PART)) otp_chk_inst (
    .CLK(CLK), .SRST(SRST),
    .reset_pin(otp_pins_if_inst.reset_pin),
    .mode_select_a(otp_pins_if_inst.mode_select_a),
    .mode_select_b(otp_pins_if_inst.mode_select_b),
    .mode_select_c(otp_pins_if_inst.mode_select_c),
    .mode_select_d(otp_pins_if_inst.mode_select_d),
    .mode_select_e(otp_pins_if_inst.mode_select_e),
    .mode_select_f(otp_pins_if_inst.mode_select_f),
    .program_strobe(otp_pins_if_inst.program_strobe),
    .vpp_applied(otp_pins_if_inst.vpp_applied),
    .port1(otp_pins_if_inst.port1),
    .port2_low(otp_pins_if_inst.port2_low),
    .vertical_sync_input_pin(otp_pins_if_inst.vertical_sync_input_pin),
    .port0_prg_oe(otp_pins_if_inst.port0_prg_oe),
    .port0_dev_out(otp_pins_if_inst.port0_dev_out),
    .port0_dev_oe(otp_pins_if_inst.port0_dev_oe));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Count one-cycle commit and refusal pulses between register polls
  always @(posedge CLK) begin
    if (SRST) begin
      n_done <= 0;
      n_refused <= 0;
    end else begin
      if (wr_done === 1'b1) n_done <= n_done + 1;
      if (wr_refused === 1'b1) n_refused <= n_refused + 1;
    end
  end

  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : check

  // Entered just after a rising edge; leaves one idle edge after release
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge CLK);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: no bus answer", $time);
      wrap_up();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge CLK);
  endtask : apb

  task run_op(input logic [2:0] op, input logic [14:0] a,
              input logic [7:0] d, output logic [7:0] rb);
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b1, `OTP_REG_ADDR, {17'h0, a}, r, e);
    apb(1'b1, `OTP_REG_WDATA, {24'h0, d}, r, e);
    apb(1'b1, `OTP_REG_CTRL, {23'h0, 1'b1, 5'h0, op}, r, e);
    n = 0;
    do begin
      apb(1'b0, `OTP_REG_STATUS, 32'h0, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 20000);
    if (r[0] !== 1'b0) begin
      errors++;
      $display("unexpected at %0t: operation never finished", $time);
      wrap_up();
    end
    check({31'h0, r[1]}, 32'h1, "done flag");
    rb = r[15:8];
    apb(1'b1, `OTP_REG_STATUS, 32'h2, r, e);
  endtask : run_op

  task t_reset_and_map;
    logic [31:0] r;
    logic        e;
    check({30'h0, fuse_one, fuse_two}, 32'h0, "fuses after reset");
    apb(1'b0, `OTP_REG_STATUS, 32'h0, r, e);
    check(r, 32'h0, "status after reset");
    apb(1'b0, 8'h10, 32'h0, r, e);
    check({r[30:0], e}, 32'h1, "unmapped access");
    $display("test reset_and_map done");
  endtask : t_reset_and_map

  task t_reads;
    logic [7:0] rb;
    run_op(3'd1, 15'h1234, 8'h00, rb);
    check({24'h0, rb}, 32'hff, "blank verify");
    run_op(3'd5, `OTP_SIG_MAKER_ADDR, 8'h00, rb);
    check({24'h0, rb}, {24'h0, MAKER}, "maker signature");
    run_op(3'd5, `OTP_SIG_PART_ADDR, 8'h00, rb);
    check({24'h0, rb}, {24'h0, PART}, "part signature");
    $display("test reads done");
  endtask : t_reads

  task t_program_strobe_code;
    logic [7:0] rb;
    int         c0;
    c0 = n_done;
    run_op(3'd0, 15'h1234, 8'h96, rb);
    check(n_done, c0 + 1, "code commit pulse");
    check(n_refused, 0, "no refusal while unlocked");
    run_op(3'd1, 15'h1234, 8'h00, rb);
    check({24'h0, rb}, 32'h96, "verify programmed byte");
    $display("test program_strobe_code done");
  endtask : t_program_strobe_code

  task t_second_fuse;
    logic [7:0] rb;
    run_op(3'd4, 15'h1234, 8'h00, rb);
    check({30'h0, fuse_one, fuse_two}, 32'h1, "second fuse only");
    check(n_done, 2, "fuse commit pulse");
    check(n_refused, 0, "fuse write accepted");
    run_op(3'd1, 15'h1234, 8'h00, rb);
    // Undriven port 0 floats to the pull-up level
    check({24'h0, rb}, 32'hff, "verify refused");
    run_op(3'd5, `OTP_SIG_MAKER_ADDR, 8'h00, rb);
    check({24'h0, rb}, {24'h0, MAKER}, "signature after fuse");
    $display("test second_fuse done");
  endtask : t_second_fuse

  initial begin
    errors = 0;
    n_compared = 0;
    SRST = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    @(posedge CLK);
    t_reset_and_map();
    t_reads();
    t_program_strobe_code();
    t_second_fuse();
    wrap_up();
  end
endmodule : otp_program_verify_port_test
